// ===== verilog/cmp_consts.vh
// Constants for the dual comparator control block
`ifndef CMP_CONSTS_VH
`define CMP_CONSTS_VH

// Register byte offsets on APB
`define OFS_CTRL_A 12'h000
`define OFS_CTRL_B 12'h004
`define OFS_INT_STATUS 12'h008
`define OFS_INT_MASK 12'h00C
`define OFS_POWER_MODE 12'h010
`define OFS_PORT_CTRL 12'h014
`define OFS_PORT_DATA 12'h018
`define OFS_PORT_READ 12'h01C

// Control register field positions
`define BIT_PIN_SELECT 7
`define BIT_POWER_ON 6
`define BIT_INVERT 5
`define BIT_RESULT 4
`define BIT_PATH_INTERNAL 3
`define BIT_HYSTERESIS_ON 0

// Writable bits of a control register (result and bits 2..1 excluded)
`define CTRL_WR_MASK 8'hE9
// Reset value of a control register
`define CTRL_RESET 8'h81

// Interrupt status/mask bit positions
`define IRQ_A 0
`define IRQ_B 1

// Power mode register bit positions
`define BIT_SLEEP 0
`define BIT_IDLE 1

`endif

// ===== verilog/dual_comparator_control.v
// Dual comparator control and status logic with APB register access
// ----------------------------------------------------------------
// Summary of operation
// - Two channels, A and B, each with its own control register of identical layout.
// - An enabled comparator releases the pull-ups on its shared input pins by itself.
// - A change of a channel's result bit sets that channel's interrupt flag, which drives its interrupt line if enabled.
// - Interrupts follow the polarity-adjusted result bit, never the external output pin level.
// - In sleep or idle, a newly set flag of an enabled comparator raises the wake request.
// - An enabled comparator keeps its status and interrupt logic running in sleep or idle.
// - With the comparator on, a shared pin's port read gives zero if its control bit is 1, else the data bit.
// - Bit 7 at 1 hands both input pins to the comparator and releases their pull-ups; their port reads depend on bit 6, not bit 7.
// - Bit 6 powers the comparator on at 1 and down at 0.
// - Bit 5 at 1 inverts the raw result before the status bit; 0 passes it.
// - Bit 4 is read-only and is 1 when plus exceeds minus with polarity 0, the reverse with polarity 1.
// - The output pin is driven only when bit 3 is 0 and bit 7 is 1.
// - Bits 2 and 1 are unimplemented and read as zero.
// - Bit 0 at 1 enables hysteresis on the comparator.
// ----------------------------------------------------------------
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/100ps
`include "cmp_consts.vh"

module dual_comparator_control #(
	parameter CHANNELS = 2,
	parameter PORT_BITS = 4
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [CHANNELS-1:0] cmp_raw_async,
	output reg [CHANNELS-1:0] cmp_power_on,
	output reg [CHANNELS-1:0] cmp_hysteresis_on,
	output reg [CHANNELS-1:0] cmp_pin_select,
	output reg [CHANNELS-1:0] pullup_release,
	output reg [CHANNELS-1:0] cmp_output_pin,
	output reg [CHANNELS-1:0] cmp_output_pin_oe,
	output reg [CHANNELS-1:0] cmp_irq,
	output reg irq,
	output reg wake_req,
	input wire [PORT_BITS-1:0] port_pin_async
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg [7:0] ctrl_reg [0:CHANNELS-1];
	reg [CHANNELS-1:0] sync1_reg;
	reg [CHANNELS-1:0] sync2_reg;
	reg [CHANNELS-1:0] result_reg;
	reg [CHANNELS-1:0] result_valid_reg;
	reg [CHANNELS-1:0] int_status_reg;
	reg [CHANNELS-1:0] int_mask_reg;
	reg [1:0] power_mode_reg;
	reg [PORT_BITS-1:0] port_ctrl_reg;
	reg [PORT_BITS-1:0] port_data_reg;
	reg [PORT_BITS-1:0] pin_sync1_reg;
	reg [PORT_BITS-1:0] pin_sync2_reg;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire bus_access = psel & penable & pready;
	wire bus_wr = bus_access & pwrite & pstrb[0];
	wire low_power = power_mode_reg[`BIT_SLEEP] | power_mode_reg[`BIT_IDLE];
	wire addr_ok = (paddr[1:0] == 2'b00) && (paddr <= `OFS_PORT_READ);

	wire [CHANNELS-1:0] adj_result;
	wire [CHANNELS-1:0] change_evt;
	wire [CHANNELS-1:0] port_enable;

	// ----------------------------------------------------------------
	// Per-channel logic
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < CHANNELS; i = i + 1) begin : g_ch
			wire on = ctrl_reg[i][`BIT_POWER_ON];
			wire sel = ctrl_reg[i][`BIT_PIN_SELECT];
			wire [31:0] ofs_full = i * 4;
			wire [11:0] my_ofs = `OFS_CTRL_A + ofs_full[11:0];
			wire ctrl_wr = bus_wr && (paddr == my_ofs);
			wire int_clr = bus_wr && (paddr == `OFS_INT_STATUS) && pwdata[i];

			// Inversion applied after synchronisation
			assign adj_result[i] = sync2_reg[i] ^ ctrl_reg[i][`BIT_INVERT];
			// Change of the adjusted status bit, not the pin level
			assign change_evt[i] = on & result_valid_reg[i] & (adj_result[i] != result_reg[i]);
			assign port_enable[i] = on;

			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ctrl_reg[i] <= `CTRL_RESET;
					sync1_reg[i] <= 1'b0;
					sync2_reg[i] <= 1'b0;
					result_reg[i] <= 1'b0;
					result_valid_reg[i] <= 1'b0;
					int_status_reg[i] <= 1'b0;
				end else begin
					if (ctrl_wr) begin
						ctrl_reg[i] <= pwdata[7:0] & `CTRL_WR_MASK;
					end
					sync1_reg[i] <= cmp_raw_async[i];
					sync2_reg[i] <= sync1_reg[i];
					// Powered-down comparator output is meaningless; hold status and rearm on enable
					if (on) begin
						result_reg[i] <= adj_result[i];
						result_valid_reg[i] <= 1'b1;
					end else begin
						result_valid_reg[i] <= 1'b0;
					end
					// Set wins over a simultaneous write-one clear
					if (change_evt[i]) begin
						int_status_reg[i] <= 1'b1;
					end else if (int_clr) begin
						int_status_reg[i] <= 1'b0;
					end
				end
			end

			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cmp_power_on[i] <= 1'b0;
					cmp_hysteresis_on[i] <= 1'b1;
					cmp_pin_select[i] <= 1'b1;
					pullup_release[i] <= 1'b1;
					cmp_output_pin[i] <= 1'b0;
					cmp_output_pin_oe[i] <= 1'b0;
					cmp_irq[i] <= 1'b0;
				end else begin
					cmp_power_on[i] <= on;
					cmp_hysteresis_on[i] <= ctrl_reg[i][`BIT_HYSTERESIS_ON];
					cmp_pin_select[i] <= sel;
					// Pull-ups drop on enable or on pin selection, whichever first
					pullup_release[i] <= on | sel;
					cmp_output_pin[i] <= result_reg[i];
					cmp_output_pin_oe[i] <= sel & ~ctrl_reg[i][`BIT_PATH_INTERNAL];
					cmp_irq[i] <= int_status_reg[i] & int_mask_reg[i];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Shared registers, interrupt, wake and port logic
	// ----------------------------------------------------------------
	// Only a newly set flag wakes; a flag already high masks the wake-up
	wire [CHANNELS-1:0] wake_evt = change_evt & cmp_power_on & ~int_status_reg;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_mask_reg <= {CHANNELS{1'b0}};
			power_mode_reg <= 2'b00;
			port_ctrl_reg <= {PORT_BITS{1'b1}};
			port_data_reg <= {PORT_BITS{1'b0}};
			pin_sync1_reg <= {PORT_BITS{1'b0}};
			pin_sync2_reg <= {PORT_BITS{1'b0}};
			irq <= 1'b0;
			wake_req <= 1'b0;
		end else begin
			pin_sync1_reg <= port_pin_async;
			pin_sync2_reg <= pin_sync1_reg;
			if (bus_wr && paddr == `OFS_INT_MASK) begin
				int_mask_reg <= pwdata[CHANNELS-1:0];
			end
			if (bus_wr && paddr == `OFS_POWER_MODE) begin
				power_mode_reg <= pwdata[1:0];
			end
			if (bus_wr && paddr == `OFS_PORT_CTRL) begin
				port_ctrl_reg <= pwdata[PORT_BITS-1:0];
			end
			if (bus_wr && paddr == `OFS_PORT_DATA) begin
				port_data_reg <= pwdata[PORT_BITS-1:0];
			end
			irq <= |(int_status_reg & int_mask_reg);
			// A flag already set before sleep produces no new edge, so no wake
			if (low_power && (|wake_evt)) begin
				wake_req <= 1'b1;
			end else if (!low_power) begin
				wake_req <= 1'b0;
			end
		end
	end

	// Port read view; pins 2k and 2k+1 belong to channel k
	reg [PORT_BITS-1:0] port_view;
	integer p;
	always @* begin
		port_view = {PORT_BITS{1'b0}};
		for (p = 0; p < PORT_BITS; p = p + 1) begin
			if ((p / 2) < CHANNELS && port_enable[p / 2]) begin
				port_view[p] = port_ctrl_reg[p] ? 1'b0 : port_data_reg[p];
			end else begin
				port_view[p] = port_ctrl_reg[p] ? pin_sync2_reg[p] : port_data_reg[p];
			end
		end
	end

	// ----------------------------------------------------------------
	// APB read and response
	// ----------------------------------------------------------------
	reg [31:0] rd_next;
	always @* begin
		rd_next = 32'h0000_0000;
		case (paddr)
			`OFS_CTRL_A: rd_next = {24'h00_0000, ctrl_reg[0][7:5], result_reg[0], ctrl_reg[0][3:0]};
			`OFS_CTRL_B: rd_next = {24'h00_0000, ctrl_reg[1][7:5], result_reg[1], ctrl_reg[1][3:0]};
			`OFS_INT_STATUS: rd_next[CHANNELS-1:0] = int_status_reg;
			`OFS_INT_MASK: rd_next[CHANNELS-1:0] = int_mask_reg;
			`OFS_POWER_MODE: rd_next[1:0] = power_mode_reg;
			`OFS_PORT_CTRL: rd_next[PORT_BITS-1:0] = port_ctrl_reg;
			`OFS_PORT_DATA: rd_next[PORT_BITS-1:0] = port_data_reg;
			`OFS_PORT_READ: rd_next[PORT_BITS-1:0] = port_view;
			default: rd_next = 32'h0000_0000;
		endcase
	end

	// One wait state: pready rises in the first access cycle's following edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			if (psel && penable && !pready) begin
				pready <= 1'b1;
				pslverr <= ~addr_ok;
				prdata <= (!pwrite && addr_ok) ? rd_next : 32'h0000_0000;
			end else begin
				pready <= 1'b0;
				pslverr <= 1'b0;
				prdata <= 32'h0000_0000;
			end
		end
	end

endmodule // dual_comparator_control

// ===== sim/cmp_ctrl_chk_sva.sv
// Concurrent checks on the ports of the dual comparator control block
`timescale 1ns/100ps
`include "cmp_consts.vh"
module cmp_ctrl_chk #(parameter CHANNELS = 2) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [CHANNELS-1:0] cmp_power_on,
	input wire [CHANNELS-1:0] cmp_hysteresis_on,
	input wire [CHANNELS-1:0] cmp_pin_select,
	input wire [CHANNELS-1:0] pullup_release,
	input wire [CHANNELS-1:0] cmp_output_pin_oe,
	input wire wake_req
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire wr_a = psel && penable && pready && pwrite && pstrb[0] && paddr == `OFS_CTRL_A;
	ready_pulse_a: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	err_unmapped_a: assert property (psel && penable && pready && (paddr > 12'h01C || paddr[1:0] != 2'b00)
		|-> pslverr) else $error("no error on unmapped");
	idle_rdata_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("stray read data");
	rsvd_zero_a: assert property (psel && pready && !pwrite && (paddr == `OFS_CTRL_A || paddr == `OFS_CTRL_B)
		|-> prdata[31:8] == 24'h00_0000 && prdata[2:1] == 2'b00) else $error("reserved bits set");
	wr_fields_a: assert property (wr_a && pwdata[7:6] == 2'b01 && !pwdata[0]
		|-> ##[1:2] cmp_power_on[0] && !cmp_pin_select[0] && !cmp_hysteresis_on[0]) else $error("ctrl write lost");
	oe_write_a: assert property (wr_a && pwdata[7] && !pwdata[3] |-> ##[1:2] cmp_output_pin_oe[0])
		else $error("output pin not driven");
	oe_sel_a: assert property ((cmp_output_pin_oe & ~cmp_pin_select) == 0) else $error("oe without select");
	pwr_pullup_a: assert property (pullup_release == (cmp_power_on | cmp_pin_select))
		else $error("pull-up release wrong");
	wake_cause_a: assert property ($rose(wake_req) |-> |cmp_power_on) else $error("wake from off comparator");
endmodule // cmp_ctrl_chk
bind dual_comparator_control cmp_ctrl_chk #(.CHANNELS(CHANNELS)) i_cmp_ctrl_chk (.*);

// ===== sim/tb_top.sv
// Self-checking testbench for the dual comparator control block
`timescale 1ns/100ps
`include "cmp_consts.vh"
module tb_top;
	logic pclk, presetn, psel, penable, pwrite, irq, wake_req;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic pready, pslverr;
	logic [1:0] raw, pw, hy, ps, pu, op, oe, ci;
	logic [3:0] pins;
	logic [32:0] exp_q[$];
	int n_errors = 0;
	int n_checks = 0;
	dual_comparator_control i_dual_comparator_control (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmp_raw_async(raw), .cmp_power_on(pw), .cmp_hysteresis_on(hy),
		.cmp_pin_select(ps), .pullup_release(pu), .cmp_output_pin(op), .cmp_output_pin_oe(oe), .cmp_irq(ci),
		.irq(irq), .wake_req(wake_req), .port_pin_async(pins));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task tally_and_finish;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Read data and error flag are noted here and compared by the monitor
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] e);
		int i;
		if (!wr) exp_q.push_back(e);
		psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready) break;
		end
		if (i == 20) begin n_errors++; tally_and_finish(); end
		psel <= 1'b0; penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wait_for(input string nm, input logic wk);
		int i;
		for (i = 0; i < 30; i++) begin
			@(posedge pclk);
			if (wk ? wake_req : irq) break;
		end
		check(nm, i < 30, 1);
	endtask
	always @(posedge pclk)
		if (psel && penable && pready && !pwrite) check("read", {pslverr, prdata}, exp_q.pop_front());
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'ha47439e3));
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 0;
		raw = 2'b00; pins = 4'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, `OFS_CTRL_A, 0, 33'h0_0000_0081);
		apb(0, `OFS_CTRL_B, 0, 33'h0_0000_0081);
		apb(0, 12'h020, 0, 33'h1_0000_0000);
		apb(1, `OFS_INT_MASK, 32'h0000_0003, 0);
		apb(1, `OFS_CTRL_A, 32'h0000_007E, 0);
		repeat (6) @(posedge pclk);
		apb(0, `OFS_CTRL_A, 0, 33'h0_0000_0078);
		check("pullup", pu, 2'b11);
		check("oe", oe, 2'b10);
		raw <= 2'b01;
		wait_for("irq", 0);
		check("outpin", op, 2'b00);
		apb(0, `OFS_INT_STATUS, 0, 33'h0_0000_0001);
		apb(1, `OFS_INT_STATUS, 32'h0000_0001, 0);
		apb(0, `OFS_INT_STATUS, 0, 33'h0_0000_0000);
		check("irq clr", irq, 0);
		apb(1, `OFS_POWER_MODE, 32'h0000_0001, 0);
		raw <= 2'b00;
		wait_for("wake", 1);
		apb(1, `OFS_POWER_MODE, 0, 0);
		apb(1, `OFS_INT_STATUS, 32'h0000_0001, 0);
		apb(1, `OFS_INT_MASK, 0, 0);
		raw <= 2'b01;
		repeat (8) @(posedge pclk);
		check("irq masked", irq, 0);
		apb(0, `OFS_INT_STATUS, 0, 33'h0_0000_0001);
		apb(1, `OFS_POWER_MODE, 32'h0000_0002, 0);
		raw <= 2'b00;
		repeat (8) @(posedge pclk);
		check("no wake", wake_req, 0);
		apb(1, `OFS_POWER_MODE, 0, 0);
		d = $urandom | 32'h0000_0040;
		apb(1, `OFS_CTRL_B, d, 0);
		repeat (6) @(posedge pclk);
		apb(0, `OFS_CTRL_B, 0, {25'h0, (d[7:0] & 8'hE9) | {3'b000, d[5], 4'h0}});
		apb(1, `OFS_CTRL_B, 32'h0000_0001, 0);
		apb(1, `OFS_CTRL_A, 32'h0000_00E1, 0);
		@(posedge pclk);
		check("oe on", oe, 2'b01);
		pins <= 4'($urandom);
		apb(1, `OFS_PORT_DATA, 32'h0000_000F, 0);
		apb(1, `OFS_PORT_CTRL, 32'h0000_0005, 0);
		apb(0, `OFS_PORT_READ, 0, {29'h0, 1'b1, pins[2], 2'b10});
		tally_and_finish();
	end
endmodule // tb_top
